// file: src/ercx_frame_checker.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: rx frame checker with tx byte ordering, for a 40/100G mac
// Assumes: pcs delivers one mii character per clock, lane 0 flagged
// Notes:   frames no longer than the 8-byte window are dropped, with no eop word
module ercx_frame_checker
  import ercx_pkg::*;
#(
  parameter bit IS_100G = 1'b1,
  parameter int NB      = 8
)(
  input  wire logic                   I_CLK,
  input  wire logic                   I_RST,
  input  wire logic                   I_CE,
  input  wire logic                   I_REG_WR,
  input  wire logic                   I_REG_RD,
  input  wire logic [11:0]            I_REG_ADDR,
  input  wire logic [31:0]            I_REG_WDATA,
  output logic      [31:0]            O_REG_RDATA,
  input  wire logic [63:0]            I_TX_DATA,
  input  wire logic                   I_TX_VALID,
  output logic      [63:0]            O_TX_MII,
  output logic                        O_TX_VALID,
  input  wire logic [7:0]             I_RX_D,
  input  wire logic                   I_RX_C,
  input  wire logic                   I_RX_LANE0,
  input  wire logic                   I_RX_VALID,
  output logic      [8*NB-1:0]        O_RX_DATA,
  output logic                        O_RX_VALID,
  output logic                        O_RX_SOP,
  output logic                        O_RX_EOP,
  output logic      [$clog2(NB)-1:0]  O_RX_EMPTY,
  output logic                        O_RX_ERROR,
  output logic                        O_RX_FCS_ERROR,
  output logic                        O_RX_FCS_VALID,
  output logic                        O_RX_RUNT,
  output logic                        O_RX_DA_MATCH,
  output logic      [1:0]             O_RX_DA_TYPE
);
  localparam int EW = $clog2(NB);
  localparam logic [13:0] TOL = IS_100G ? TOL_100G : TOL_40G;
  localparam logic [EW-1:0] IDX_LAST = EW'(NB - 1);

  // reflected crc update, one byte, lsb first
  function automatic logic [31:0] crc_next(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // registers and state
  logic [3:0]      ctrl_q;
  logic            crc_rm_q;
  logic [13:0]     max_q;
  logic [47:0]     mac_q;
  logic [1:0]      pause_q;
  logic [5:0]      stat_q;
  ercx_state_type  state_q;
  ercx_state_type  state_d;
  logic [2:0]      pre_q;
  logic [13:0]     len_q;
  logic [31:0]     crc_q;
  logic [47:0]     da_q;
  logic [7:0]      pipe_q [8];
  logic [3:0]      left_q;
  ercx_end_type    end_q;
  logic            keep_q;
  logic            match_q;
  ercx_da_type     dtype_q;
  logic [8*NB-1:0] acc_q;
  logic [EW-1:0]   idx_q;
  logic            sop_pend_q;

  ////////////////////////////////////////////////////////////////////////////////
  // tx ordering: first client octet moves to mii lane 0
  logic [63:0] tx_rev_w;
  for (genvar g = 0; g < 8; g++)
  begin : g_rev
    assign tx_rev_w[8*g +: 8] = I_TX_DATA[63-8*g -: 8];
  end

  // one-cycle register stage toward the pcs
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      O_TX_MII   <= 64'h0;
      O_TX_VALID <= 1'b0;
    end
    else if (I_CE)
    begin
      O_TX_VALID <= I_TX_VALID;
      if (I_TX_VALID)
        O_TX_MII <= tx_rev_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register port decode
  wire wr_ctrl  = I_REG_WR & (I_REG_ADDR == CTRL_OFS);
  wire wr_crc   = I_REG_WR & (I_REG_ADDR == CRC_OFS);
  wire wr_max   = I_REG_WR & (I_REG_ADDR == MAXLEN_OFS);
  wire wr_mlo   = I_REG_WR & (I_REG_ADDR == MAC_LO_OFS);
  wire wr_mhi   = I_REG_WR & (I_REG_ADDR == MAC_HI_OFS);
  wire wr_pause = I_REG_WR & (I_REG_ADDR == PAUSE_OFS);
  // writes above the cap clamp to it, keeping the limit in range
  wire         max_big = (I_REG_WDATA[31:14] != 18'h0) | (I_REG_WDATA[13:0] > MAX_CAP);
  wire [13:0]  max_w   = max_big ? MAX_CAP : I_REG_WDATA[13:0];
  wire [31:0]  rd_w    =
      (I_REG_ADDR == CTRL_OFS)   ? {28'h0, ctrl_q} :
      (I_REG_ADDR == CRC_OFS)    ? {31'h0, crc_rm_q} :
      (I_REG_ADDR == MAXLEN_OFS) ? {18'h0, max_q} :
      (I_REG_ADDR == MAC_LO_OFS) ? mac_q[31:0] :
      (I_REG_ADDR == MAC_HI_OFS) ? {16'h0, mac_q[47:32]} :
      (I_REG_ADDR == PAUSE_OFS)  ? {30'h0, pause_q} :
      (I_REG_ADDR == STAT_OFS)   ? {23'h0, state_q, stat_q} : 32'h0;

  // software-visible registers; unmapped reads return zero
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      ctrl_q      <= CTRL_RST;
      crc_rm_q    <= CRC_RM_RST;
      max_q       <= MAX_CAP;
      mac_q       <= MAC_RST;
      pause_q     <= 2'h0;
      O_REG_RDATA <= 32'h0;
    end
    else if (I_CE)
    begin
      if (wr_ctrl)  ctrl_q <= I_REG_WDATA[3:0];
      if (wr_crc)   crc_rm_q <= I_REG_WDATA[0];
      if (wr_max)   max_q <= max_w;
      if (wr_mlo)   mac_q[31:0] <= I_REG_WDATA;
      if (wr_mhi)   mac_q[47:32] <= I_REG_WDATA[15:0];
      if (wr_pause) pause_q <= I_REG_WDATA[1:0];
      O_REG_RDATA <= I_REG_RD ? rd_w : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // character classes; a gap in rx valid is simply no character
  wire rx_ok   = I_CE & I_RX_VALID;
  wire is_data = rx_ok & ~I_RX_C;
  wire is_ctl  = rx_ok & I_RX_C;
  wire is_strt = is_ctl & (I_RX_D == CH_START) & I_RX_LANE0;
  wire in_data = (state_q == ST_DATA);
  wire data_in = in_data & is_data;
  wire term_in = in_data & is_ctl;
  wire flush   = (state_q == ST_FLUSH) & I_CE;
  // frames not longer than the window cannot be represented; dropped
  wire too_short = (len_q <= PIPE_DEPTH);

  // preamble and frame sequencing
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (is_strt) state_d = ST_PRE;
      ST_PRE:
        if (rx_ok)
        begin
          if (I_RX_C || I_RX_D != CH_PRE) state_d = ST_DISC;
          else if (pre_q == PRE_LAST)     state_d = ST_SFD;
        end
      ST_SFD:
        if (rx_ok)
          state_d = (!I_RX_C && I_RX_D == CH_SFD) ? ST_DATA : ST_DISC;
      ST_DATA:
        if (is_ctl) state_d = too_short ? ST_IDLE : ST_FLUSH;
      ST_FLUSH:
        if (I_CE && left_q == 4'h1) state_d = ST_IDLE;
      ST_DISC:
        if (is_ctl) state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // end-of-frame checks, using the count that includes the fcs
  wire [14:0] lim_w   = {1'b0, max_q} + {1'b0, TOL};
  wire        over_w  = {1'b0, len_q} > lim_w;
  wire        runt_w  = len_q < MIN_FRAME;
  wire        fcs_bad = crc_q != CRC_RESIDUE;

  // address filter, decided as the first byte leaves the window
  wire da_mis  = (da_q != mac_q);
  wire pass_w  = ctrl_q[CTL_PROMISC] | ~ctrl_q[CTL_MATCH] | ~(ctrl_q[CTL_FILTER] & da_mis);
  wire first_w = data_in & (len_q == PIPE_DEPTH);
  wire keep_w  = first_w ? pass_w : keep_q;
  ercx_da_type dtype_w;
  assign dtype_w = (&da_q) ? DA_BCAST : (da_q[40] ? DA_MULTI : DA_UNI);

  // byte stream out of the window; delimiters never enter it
  wire        emit_w  = (data_in & (len_q >= PIPE_DEPTH)) | flush;
  wire        bs_val  = emit_w & keep_w;
  wire        bs_eop  = flush & (left_q == 4'h1);
  wire [7:0]  bs_data = pipe_q[7];
  wire        sh_w    = data_in | flush;

  // frame tracking: counters, crc, address capture
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_q <= ST_IDLE;
      pre_q   <= 3'h0;
      len_q   <= 14'h0;
      crc_q   <= CRC_INIT;
      da_q    <= 48'h0;
      left_q  <= 4'h0;
      end_q   <= '0;
      keep_q  <= 1'b0;
      match_q <= 1'b0;
      dtype_q <= DA_UNI;
      stat_q  <= 6'h0;
    end
    else if (I_CE)
    begin
      state_q <= state_d;
      if (state_q == ST_IDLE)
      begin
        pre_q <= 3'h0;
        len_q <= 14'h0;
        crc_q <= CRC_INIT;
      end
      if (state_q == ST_PRE && rx_ok)
        pre_q <= pre_q + 3'h1;
      if (data_in)
      begin
        if (len_q != 14'h3FFF) len_q <= len_q + 14'h1;
        crc_q <= crc_next(crc_q, I_RX_D);
        if (len_q < DA_BYTES) da_q <= {da_q[39:0], I_RX_D};
      end
      if (term_in)
      begin
        end_q  <= '{fcs_bad, runt_w, over_w, I_RX_D != CH_TERM};
        left_q <= crc_rm_q ? FLUSH_RM : FLUSH_ALL;
      end
      if (flush)
        left_q <= left_q - 4'h1;
      if (first_w)
      begin
        keep_q  <= pass_w;
        match_q <= ~da_mis;
        dtype_q <= dtype_w;
      end
      if (bs_val && bs_eop)
        stat_q <= {dtype_q, end_q.fcs_bad, end_q.runt, end_q.over, end_q.bad_ch};
    end
  end

  // eight-byte window; fcs bytes sit here when the frame ends
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < 8; i++) pipe_q[i] <= 8'h0;
    end
    else if (sh_w)
    begin
      pipe_q[0] <= data_in ? I_RX_D : 8'h0;
      for (int i = 1; i < 8; i++) pipe_q[i] <= pipe_q[i-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // widening to the client word, first byte of a packet at the msb
  wire [EW-1:0]   pos_w  = IDX_LAST - idx_q;
  wire [8*NB-1:0] word_w = acc_q | ({{(8*NB-8){1'b0}}, bs_data} << (8 * pos_w));
  wire            last_w = bs_eop | (idx_q == IDX_LAST);
  wire            err_w  = end_q.fcs_bad | end_q.over | end_q.bad_ch | (end_q.runt & ctrl_q[CTL_RUNT]);

  // client word output; a packet always starts a fresh word
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      acc_q          <= '0;
      idx_q          <= '0;
      sop_pend_q     <= 1'b0;
      O_RX_DATA      <= '0;
      O_RX_VALID     <= 1'b0;
      O_RX_SOP       <= 1'b0;
      O_RX_EOP       <= 1'b0;
      O_RX_EMPTY     <= '0;
      O_RX_ERROR     <= 1'b0;
      O_RX_FCS_ERROR <= 1'b0;
      O_RX_FCS_VALID <= 1'b0;
      O_RX_RUNT      <= 1'b0;
      O_RX_DA_MATCH  <= 1'b0;
      O_RX_DA_TYPE   <= 2'h0;
    end
    else if (I_CE)
    begin
      O_RX_VALID <= bs_val & last_w;
      if (bs_val && last_w)
      begin
        O_RX_DATA      <= word_w;
        O_RX_SOP       <= sop_pend_q | first_w;
        O_RX_EOP       <= bs_eop;
        O_RX_EMPTY     <= bs_eop ? pos_w : '0;
        O_RX_ERROR     <= bs_eop & err_w;
        O_RX_FCS_ERROR <= bs_eop & end_q.fcs_bad;
        O_RX_FCS_VALID <= bs_eop;
        O_RX_RUNT      <= bs_eop & end_q.runt;
        O_RX_DA_MATCH  <= first_w ? ~da_mis : match_q;
        O_RX_DA_TYPE   <= first_w ? dtype_w : dtype_q;
        acc_q          <= '0;
        idx_q          <= '0;
        sop_pend_q     <= 1'b0;
      end
      else if (bs_val)
      begin
        acc_q      <= word_w;
        idx_q      <= idx_q + EW'(1);
        sop_pend_q <= sop_pend_q | first_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_eop_fcs;
    O_RX_VALID && O_RX_EOP |-> O_RX_FCS_VALID;
  endproperty
  a_eop_fcs: assert property (p_eop_fcs) else $error("eop without fcs valid");

  // the flag holds after the eop word, so judge it only on the word itself
  property p_fcs_err;
    O_RX_VALID && O_RX_FCS_ERROR |-> O_RX_EOP && O_RX_FCS_VALID && O_RX_ERROR;
  endproperty
  a_fcs_err: assert property (p_fcs_err) else $error("fcs error off eop");

  property p_crc_rst;
    $fell(I_RST) |-> crc_rm_q;
  endproperty
  a_crc_rst: assert property (p_crc_rst) else $error("fcs removal off after reset");

  property p_sfd;
    (state_q == ST_DATA) && ($past(state_q) != ST_DATA)
      |-> ($past(state_q) == ST_SFD) && ($past(I_RX_D) == CH_SFD);
  endproperty
  a_sfd: assert property (p_sfd) else $error("data entered without delimiter");

  property p_lane0;
    (state_q == ST_IDLE) && I_CE && I_RX_VALID && I_RX_C && !I_RX_LANE0 |=> state_q == ST_IDLE;
  endproperty
  a_lane0: assert property (p_lane0) else $error("start accepted off lane 0");

  property p_tx;
    I_CE && I_TX_VALID |=> O_TX_VALID && (O_TX_MII[7:0] == $past(I_TX_DATA[63:56]))
      && (O_TX_MII[63:56] == $past(I_TX_DATA[7:0]));
  endproperty
  a_tx: assert property (p_tx) else $error("tx byte order wrong");

  // kept runt with fcs removal: four flush cycles, eop word one later
  property p_runt;
    term_in && !too_short && runt_w && ctrl_q[CTL_RUNT] && keep_q && crc_rm_q
      |-> ##5 O_RX_VALID && O_RX_EOP && O_RX_ERROR && O_RX_RUNT;
  endproperty
  a_runt: assert property (p_runt) else $error("runt not flagged");

  property p_max;
    max_q <= MAX_CAP;
  endproperty
  a_max: assert property (p_max) else $error("max frame above cap");

  property p_over;
    term_in && ({1'b0, len_q} > ({1'b0, max_q} + {1'b0, TOL})) |=> end_q.over;
  endproperty
  a_over: assert property (p_over) else $error("oversize not caught");

  property p_promisc;
    first_w && ctrl_q[CTL_PROMISC] |-> bs_val;
  endproperty
  a_promisc: assert property (p_promisc) else $error("promiscuous frame dropped");

  c_good:  cover property (O_RX_VALID && O_RX_EOP && !O_RX_ERROR);
  c_bad:   cover property (O_RX_FCS_ERROR);
  c_drop:  cover property (first_w && !pass_w);
  c_keepf: cover property (O_RX_VALID && O_RX_EOP && !crc_rm_q);
endmodule

// file: src/ercx_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// Purpose: constants and types shared by the rx frame checker
// Assumes: byte-serial mii lane stream, one clock domain
// Notes:   register offsets are word addresses on the register port
package ercx_pkg;
  // register offsets
  localparam logic [11:0] CTRL_OFS    = 12'h103;
  localparam logic [11:0] CRC_OFS     = 12'h104;
  localparam logic [11:0] MAXLEN_OFS  = 12'h105;
  localparam logic [11:0] MAC_LO_OFS  = 12'h106;
  localparam logic [11:0] MAC_HI_OFS  = 12'h107;
  localparam logic [11:0] PAUSE_OFS   = 12'h108;
  localparam logic [11:0] STAT_OFS    = 12'h109;
  // filter and runt control field positions
  localparam int CTL_MATCH   = 0;
  localparam int CTL_FILTER  = 1;
  localparam int CTL_PROMISC = 2;
  localparam int CTL_RUNT    = 3;
  // values after reset
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic        CRC_RM_RST = 1'b1;
  localparam logic [13:0] MAX_CAP    = 14'h2580;
  localparam logic [47:0] MAC_RST    = 48'h0;
  // line characters
  localparam logic [7:0] CH_START = 8'hFB;
  localparam logic [7:0] CH_TERM  = 8'hFD;
  localparam logic [7:0] CH_PRE   = 8'h55;
  localparam logic [7:0] CH_SFD   = 8'hD5;
  // counts
  localparam logic [2:0]  PRE_LAST   = 3'h5;
  localparam logic [13:0] MIN_FRAME  = 14'h0040;
  localparam logic [13:0] PIPE_DEPTH = 14'h0008;
  localparam logic [13:0] DA_BYTES   = 14'h0006;
  localparam logic [13:0] TOL_100G   = 14'h002C;
  localparam logic [13:0] TOL_40G    = 14'h0014;
  localparam logic [3:0]  FLUSH_RM   = 4'h4;
  localparam logic [3:0]  FLUSH_ALL  = 4'h8;
  // crc-32, reflected form
  localparam logic [31:0] CRC_INIT    = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY    = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PRE   = 3'h1,
    ST_SFD   = 3'h3,
    ST_DATA  = 3'h2,
    ST_FLUSH = 3'h6,
    ST_DISC  = 3'h7
  } ercx_state_type;

  typedef enum logic [1:0] {
    DA_UNI   = 2'h0,
    DA_MULTI = 2'h1,
    DA_BCAST = 2'h3
  } ercx_da_type;

  typedef struct packed {
    logic fcs_bad;
    logic runt;
    logic over;
    logic bad_ch;
  } ercx_end_type;
endpackage

// file: verification/ercx_pcs_model.sv
////////////////////////////////////////////////
// Purpose: pcs receive lane model feeding mii characters
// Assumes: one character per clock, same clock as the checker
// Notes:   idle data line shows the inverted last value, never a stale copy
module ercx_pcs_model
  import ercx_pkg::*;
(
  input  wire logic       i_clk,
  output logic      [7:0] o_d,
  output logic            o_c,
  output logic            o_lane0,
  output logic            o_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_d     = 8'h00;
    o_c     = 1'b1;
    o_lane0 = 1'b0;
    o_valid = 1'b0;
  end

  ////////////////////////////////////////////////
  // one character per edge, changed right after the edge
  task automatic put(input logic [7:0] d, input logic c, input logic l0);
    @(posedge i_clk);
    o_d     <= d;
    o_c     <= c;
    o_lane0 <= l0;
    o_valid <= 1'b1;
  endtask

  // gap cycle: valid low, data flipped so nothing stale can be mistaken
  task automatic idle;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_d     <= ~o_d;
    o_lane0 <= 1'b0;
  endtask

  // start with lane 0 flag l0, npre preamble bytes, delimiter, data, terminate
  task automatic send_frame(input logic [7:0] b[$], input int npre, input int gap_at,
                            input logic l0);
    int i;
    put(CH_START, 1'b1, l0);
    for (i = 0; i < npre; i++)
      put(CH_PRE, 1'b0, 1'b0);
    put(CH_SFD, 1'b0, 1'b0);
    for (i = 0; i < b.size(); i++)
    begin
      if (i == gap_at)
        idle();
      put(b[i], 1'b0, 1'b0);
    end
    put(CH_TERM, 1'b1, 1'b0);
    idle();
  endtask
endmodule

// file: verification/ercx_frame_checker_test.sv
////////////////////////////////////////////////
// Purpose: self-checking bench for the rx frame checker
// Assumes: NB=8, 100g tolerance, clock enable held high except in t_ce
// Notes:   expected bytes and crc are built here, not read back
module ercx_frame_checker_test
  import ercx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        ce;
  logic        reg_wr;
  logic        reg_rd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [63:0] tx_data;
  logic        tx_valid;
  logic [63:0] tx_mii;
  logic        tx_ovalid;
  logic [7:0]  rx_d;
  logic        rx_c;
  logic        rx_lane0;
  logic        rx_valid;
  logic [63:0] rx_data;
  logic        rx_ovalid;
  logic        rx_sop;
  logic        rx_eop;
  logic [2:0]  rx_empty;
  logic        rx_err;
  logic        fcs_err;
  logic        fcs_vld;
  logic        rx_runt;
  logic        da_match;
  logic [1:0]  da_type;
  logic [7:0]  frm[$];
  logic [7:0]  got[$];
  logic [5:0]  flg;
  logic        eop_seen;
  int          nwords;
  int          miscompares;
  int          checked;

  ercx_frame_checker u_dut (
    .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
    .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .O_REG_RDATA(reg_rdata),
    .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid), .O_TX_MII(tx_mii), .O_TX_VALID(tx_ovalid),
    .I_RX_D(rx_d), .I_RX_C(rx_c), .I_RX_LANE0(rx_lane0), .I_RX_VALID(rx_valid),
    .O_RX_DATA(rx_data), .O_RX_VALID(rx_ovalid), .O_RX_SOP(rx_sop), .O_RX_EOP(rx_eop),
    .O_RX_EMPTY(rx_empty), .O_RX_ERROR(rx_err), .O_RX_FCS_ERROR(fcs_err),
    .O_RX_FCS_VALID(fcs_vld), .O_RX_RUNT(rx_runt), .O_RX_DA_MATCH(da_match),
    .O_RX_DA_TYPE(da_type));

  ercx_pcs_model u_pcs (
    .i_clk(clk), .o_d(rx_d), .o_c(rx_c), .o_lane0(rx_lane0), .o_valid(rx_valid));

  always #20 clk = ~clk;

  ////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic reg_w(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_r(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // first octet sent is the top address byte; fcs low byte goes first
  task automatic build(input logic [47:0] da, input int len);
    logic [31:0] crc;
    int          i;
    int          k;
    frm = {};
    for (i = 0; i < 6; i++)
      frm.push_back(da[47-8*i -: 8]);
    for (i = 6; i < len - 4; i++)
      frm.push_back(8'(i));
    crc = CRC_INIT;
    for (i = 0; i < frm.size(); i++)
    begin
      crc = crc ^ {24'h0, frm[i]};
      for (k = 0; k < 8; k++)
        crc = crc[0] ? ((crc >> 1) ^ CRC_POLY) : (crc >> 1);
    end
    crc = ~crc;
    for (i = 0; i < 4; i++)
      frm.push_back(crc[8*i +: 8]);
  endtask

  // gather every valid word until eop, bounded
  task automatic collect;
    int n;
    int i;
    for (n = 0; n < 400 && !eop_seen; n++)
    begin
      @(posedge clk);
      #1;
      if (rx_ovalid === 1'b1)
      begin
        nwords++;
        chk(rx_sop, {31'h0, nwords == 1});
        for (i = 0; i < ((rx_eop === 1'b1) ? 8 - rx_empty : 8); i++)
          got.push_back(rx_data[63-8*i -: 8]);
        if (rx_eop === 1'b1)
        begin
          flg      = {fcs_vld, fcs_err, rx_runt, rx_err, da_type};
          eop_seen = 1'b1;
        end
      end
    end
  endtask

  task automatic run(input int npre);
    got      = {};
    nwords   = 0;
    eop_seen = 1'b0;
    fork
      u_pcs.send_frame(frm, npre, 20, 1'b1);
      collect();
    join
    repeat (12) @(posedge clk);
  endtask

  // a missing eop is a hang: counted, then the run is closed
  task automatic expect_frame(input int nb, input logic [5:0] ef);
    int i;
    if (!eop_seen)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      close_out();
    end
    else
    begin
      chk(got.size(), nb);
      for (i = 0; i < nb && i < got.size(); i++)
        chk(got[i], frm[i]);
      chk(flg, ef);
    end
  endtask

  ////////////////////////////////////////////////
  task automatic t_regs;
    reg_r(CTRL_OFS, 32'h0);
    reg_r(CRC_OFS, 32'h1);
    reg_r(MAXLEN_OFS, 32'h2580);
    reg_w(MAXLEN_OFS, 32'h3000);
    reg_r(MAXLEN_OFS, 32'h2580);
    reg_r(12'h200, 32'h0);
    reg_w(PAUSE_OFS, 32'h3);
    reg_r(PAUSE_OFS, 32'h3);
    reg_w(PAUSE_OFS, 32'h0);
  endtask

  task automatic t_tx;
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data  <= 64'h0102030405060708;
    @(posedge clk);
    tx_valid <= 1'b0;
    #1;
    chk(tx_ovalid, 1'b1);
    chk(tx_mii[31:0], 32'h04030201);
    chk(tx_mii[63:32], 32'h08070605);
  endtask

  // clock enable low freezes the tx stage; the held word passes once it rises
  task automatic t_ce;
    @(posedge clk);
    ce       <= 1'b0;
    tx_valid <= 1'b1;
    tx_data  <= 64'h1122334455667788;
    repeat (2) @(posedge clk);
    #1;
    chk(tx_ovalid, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    tx_valid <= 1'b0;
    #1;
    chk(tx_ovalid, 1'b1);
    chk(tx_mii[31:0], 32'h44332211);
    chk(tx_mii[63:32], 32'h88776655);
  endtask

  task automatic t_fcs;
    build(48'hFFFFFFFFFFFF, 64);
    run(6);
    expect_frame(60, {4'b1000, DA_BCAST});
    frm[63] = frm[63] ^ 8'h01;
    run(6);
    expect_frame(60, {4'b1101, DA_BCAST});
    reg_r(STAT_OFS, 32'h38);
    reg_w(CRC_OFS, 32'h0);
    build(48'h020000000000, 64);
    run(6);
    expect_frame(64, {4'b1000, DA_UNI});
    reg_w(CRC_OFS, 32'h1);
  endtask

  // runt delivered with error marking on, then pause frame passes as plain multicast
  task automatic t_len;
    reg_w(CTRL_OFS, 32'h8);
    build(48'h010000000001, 40);
    run(6);
    expect_frame(36, {4'b1011, DA_MULTI});
    reg_w(CTRL_OFS, 32'h0);
    build(48'h0180C2000001, 64);
    run(6);
    expect_frame(60, {4'b1000, DA_MULTI});
    reg_w(MAXLEN_OFS, 32'h40);
    build(48'hFFFFFFFFFFFF, 109);
    run(6);
    expect_frame(105, {4'b1001, DA_BCAST});
    reg_w(MAXLEN_OFS, 32'h2580);
    run(5);
    chk(nwords, 0);
  endtask

  // start character off lane 0 is ignored, so the whole frame is lost
  task automatic t_lane;
    got      = {};
    nwords   = 0;
    eop_seen = 1'b0;
    fork
      u_pcs.send_frame(frm, 6, 20, 1'b0);
      collect();
    join
    chk(nwords, 0);
  endtask

  task automatic t_addr;
    reg_w(MAC_LO_OFS, 32'h00000005);
    reg_w(MAC_HI_OFS, 32'h00000200);
    reg_r(MAC_HI_OFS, 32'h00000200);
    reg_w(CTRL_OFS, 32'h3);
    build(48'h020000000005, 64);
    run(6);
    chk(nwords, 8);
    expect_frame(60, {4'b1000, DA_UNI});
    chk(da_match, 1'b1);
    build(48'h020000000006, 64);
    run(6);
    chk(nwords, 0);
    reg_w(CTRL_OFS, 32'h1);
    run(6);
    chk(nwords, 8);
    expect_frame(60, {4'b1000, DA_UNI});
    chk(da_match, 1'b0);
    reg_w(CTRL_OFS, 32'h7);
    run(6);
    chk(nwords, 8);
    expect_frame(60, {4'b1000, DA_UNI});
    reg_w(CTRL_OFS, 32'h0);
  endtask

  ////////////////////////////////////////////////
  initial
  begin
    clk         = 1'b0;
    rst         = 1'b1;
    ce          = 1'b1;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 12'h000;
    reg_wdata   = 32'h0;
    tx_data     = 64'h0;
    tx_valid    = 1'b0;
    miscompares = 0;
    checked     = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_tx();
    t_ce();
    t_fcs();
    t_len();
    t_lane();
    t_addr();
    close_out();
  end
endmodule
